// ### dv/testbench.sv
// Self-checking bench for the timer clock and clear select block.
// Assumes APB answers with one wait and pins sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tcc_pkg::*;
  logic clk = 0, rst = 1, stby = 0, psel = 0, pen = 0, pw = 0, pready, perr, er;
  logic [7:0] pa = 0;
  logic [31:0] pwd = 0, prd, rd, rnd, seed = 32'hea634e60;
  logic [3:0] pst = 0, pins = 0;
  logic [4:0] cmpa = 0, capa = 0, acap = 0, cmpb = 0, capb = 0, bcap = 0, clr, seen;
  int errors = 0, checks_done = 0, cyc = 0, t1, t2, c1, c2, e, dv;
  int q[$];
  int cs[8][5] = '{'{1,0,0,0,1}, '{1,0,0,1,0}, '{1,1,0,1,1}, '{2,0,0,2,1},
                   '{2,0,1,3,1}, '{2,0,0,0,0}, '{0,0,0,0,0}, '{2,0,1,2,0}};
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  timer_clock_clear_select timer_clock_clear_select_inst (.SYS_CLK_I(clk), .SRST_I(rst),
    .STBY_I(stby), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pw), .PADDR_I(pa),
    .PWDATA_I(pwd), .PSTRB_I(pst), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr),
    .EXT_CLK_IN_A_I(pins[0]), .EXT_CLK_IN_B_I(pins[1]), .EXT_CLK_IN_C_I(pins[2]),
    .EXT_CLK_IN_D_I(pins[3]), .CMP_A_I(cmpa), .CAP_A_I(capa), .A_IS_CAPTURE_I(acap),
    .CMP_B_I(cmpb), .CAP_B_I(capb), .B_IS_CAPTURE_I(bcap), .CNT_CLR_O(clr));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1;
    pw <= w;
    pa <= a;
    pwd <= d;
    pst <= s;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task rdc(input int ch, output int v, output int t);
    apb(0, CNT_BASE + 8'(4 * ch), 0, 0);
    v = rd[15:0];
    t = cyc;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < NUM_CH; i++) begin
      apb(0, CTL_BASE + 8'(4 * i), 0, 0);
      chk(rd, 0);
      rnd = xs() & 32'hff;
      apb(1, CTL_BASE + 8'(4 * i), rnd, 4'h1);
      apb(0, CTL_BASE + 8'(4 * i), 0, 0);
      chk(rd, rnd);
    end
    for (int i = 0; i < NUM_BUF; i++) begin
      apb(0, BUF_BASE + 8'(4 * i), 0, 0);
      chk(rd, 32'h0000ffff);
    end
    apb(1, BUF_BASE + 8'h04, 32'h1234, 4'h1);
    apb(0, BUF_BASE + 8'h04, 0, 0);
    chk(rd, 32'h0000ff34);
    apb(0, 8'hf0, 0, 0);
    chk(32'(er), 1);
    @(posedge clk);
    stby <= 1;
    @(posedge clk);
    stby <= 0;
    apb(0, CTL_BASE + 8'h10, 0, 0);
    chk(rd, 0);
    apb(0, BUF_BASE + 8'h04, 0, 0);
    chk(rd, 32'h0000ffff);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      apb(1, CTL_BASE, 32'(k) | (xs() & 32'h98), 4'h1);
      rdc(0, c1, t1);
      repeat (40) @(posedge clk);
      rdc(0, c2, t2);
      dv = (c2 - c1) & 32'hffff;
      e = t2 - t1;
      chk(32'(dv >= (e >> k) && dv <= (e >> k) + 1), 1);
    end
    $display("test internal done");
    for (int k = 4; k < 8; k++) begin
      for (int m = 0; m < 3; m++) begin
        apb(1, CTL_BASE + 8'h04, 32'(k | (m << 3)), 4'h1);
        rdc(1, c1, t1);
        q = {pins[k - 4]};
        repeat (12) begin
          rnd = xs();
          pins <= rnd[3:0];
          q.push_back(rnd[k - 4]);
          repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        rdc(1, c2, t2);
        e = 0;
        for (int j = 1; j < q.size(); j++) begin
          e += int'((m != 1 && !q[j - 1] && q[j]) || (m != 0 && q[j - 1] && !q[j]));
        end
        chk((c2 - c1) & 32'hffff, e);
      end
    end
    $display("test external done");
    apb(1, CTL_BASE, 32'h60, 4'h1);
    apb(1, SYNC_OFF, 32'h09, 4'h1);
    foreach (cs[i]) begin
      apb(1, CTL_BASE + 8'h0c, 32'(cs[i][0] << 5), 4'h1);
      acap <= 5'(cs[i][1] << 3);
      bcap <= 5'(cs[i][2] << 3);
      @(posedge clk);
      {cmpa, capa, cmpb, capb} <= 20'h8 << (5 * (3 - cs[i][3]));
      @(posedge clk);
      {cmpa, capa, cmpb, capb} <= '0;
      seen = 0;
      repeat (4) begin
        @(posedge clk);
        seen |= clr;
      end
      chk(seen, cs[i][4] ? 5'h09 : 5'h00);
    end
    $display("test clear done");
    pins <= 0;
    repeat (4) @(posedge clk);
    apb(1, PHASE_OFF, 1, 4'h1);
    apb(1, CTL_BASE + 8'h08, 0, 4'h1);
    rdc(2, c1, t1);
    repeat (16) @(posedge clk);
    pins <= 4'h1;
    repeat (3) @(posedge clk);
    pins <= 4'h3;
    repeat (6) @(posedge clk);
    rdc(2, c2, t2);
    chk((c2 - c1) & 32'hffff, 2);
    $display("test phase done");
    finish_test();
  end
endmodule // testbench
`default_nettype wire

// ### rtl/tcc_buf_mem.sv
// Four 16-bit buffer registers with byte writes and registered read data.
// Assumes one clock and a synchronous active-high reset or standby.
`timescale 1ns/1ps
`default_nettype none
module tcc_buf_mem
  import tcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [1:0] be_i,
  input wire logic [1:0] waddr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] raddr_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem_r [NUM_BUF];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_BUF; i++) mem_r[i] <= BUF_RST;
    end else if (we_i) begin
      if (be_i[0]) mem_r[waddr_i][7:0] <= wdata_i[7:0];
      if (be_i[1]) mem_r[waddr_i][15:8] <= wdata_i[15:8];
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem_r[raddr_i];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  buf_reset_a: assert property ($past(rst_i) && !we_i |=> rdata_o == BUF_RST)
    else $error("buffer not all ones after reset");
  buf_byte_a: assert property (we_i && be_i == 2'h1 && raddr_i == waddr_i ##1
      raddr_i == $past(waddr_i) && !we_i |=> rdata_o[15:8] == $past(rdata_o[15:8],2))
    else $error("low byte write disturbed high byte");
endmodule // tcc_buf_mem
`default_nettype wire

// ### rtl/tcc_pkg.sv
// Constants for the timer clock and clear select block.
// Assumes a 32-bit APB master with an 8-bit byte address.
package tcc_pkg;
  localparam int NUM_CH = 5;
  localparam int PH_CH = 2;
  localparam int NUM_BUF = 4;
  // Byte offsets
  localparam logic [7:0] CTL_BASE = 8'h00;
  localparam logic [7:0] CNT_BASE = 8'h20;
  localparam logic [7:0] BUF_BASE = 8'h40;
  localparam logic [7:0] SYNC_OFF = 8'h50;
  localparam logic [7:0] PHASE_OFF = 8'h54;
  // Reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] BUF_RST = 16'hffff;
  localparam logic [4:0] SYNC_RST = 5'h00;
  // Control field positions
  localparam int RSVD_BIT = 7;
  localparam int CLR_HI = 6;
  localparam int CLR_LO = 5;
  localparam int EDGE_HI = 4;
  localparam int EDGE_LO = 3;
  localparam int PSC_HI = 2;
  localparam int PSC_LO = 0;
  // Clear source codes
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_GRA = 2'h1;
  localparam logic [1:0] CLR_GRB = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;
  // Edge codes
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  // Prescaler divider width: phi/8 needs three bits
  localparam int DIV_W = 3;
endpackage

// ### rtl/timer_clock_clear_select.sv
// Five-channel counter clock and clear select with APB registers.
// Assumes a 10 MHz clock, pins synchronous to it, general register
// events given as one-cycle pulses from the compare/capture logic.
`timescale 1ns/1ps
`default_nettype none
module timer_clock_clear_select
  import tcc_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic SRST_I,
  input wire logic STBY_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic EXT_CLK_IN_A_I,
  input wire logic EXT_CLK_IN_B_I,
  input wire logic EXT_CLK_IN_C_I,
  input wire logic EXT_CLK_IN_D_I,
  input wire logic [4:0] CMP_A_I,
  input wire logic [4:0] CAP_A_I,
  input wire logic [4:0] A_IS_CAPTURE_I,
  input wire logic [4:0] CMP_B_I,
  input wire logic [4:0] CAP_B_I,
  input wire logic [4:0] B_IS_CAPTURE_I,
  output logic [4:0] CNT_CLR_O
);
  logic rst;
  logic [7:0] ctl_r [NUM_CH];
  logic [15:0] cnt_r [NUM_CH];
  logic [4:0] sync_sel_r;
  logic phase_count_enable_r;
  logic [DIV_W-1:0] div_r;
  logic [3:0] ext_now;
  logic [3:0] ext_prev_r;
  logic [4:0] own_clr;
  logic [4:0] clr;
  logic [4:0] tick;
  logic sync_hit;
  logic ph_up;
  logic ph_dn;
  logic acc;
  logic wr;
  logic [31:0] rd_mux;
  logic rd_err;
  logic [15:0] buf_rdata;
  logic buf_hit;

  assign rst = SRST_I | STBY_I;
  assign ext_now = {EXT_CLK_IN_D_I, EXT_CLK_IN_C_I, EXT_CLK_IN_B_I, EXT_CLK_IN_A_I};
  assign acc = PSEL_I & PENABLE_I;
  assign wr = acc & PWRITE_I & PREADY_O;

  // Prescaled tap: falling edge of phi/2^sel is the cycle its divider bit wraps
  function automatic logic int_tick(input logic [1:0] sel, input logic [DIV_W-1:0] div);
    logic t;
    t = 1'b1;
    for (int k = 0; k < DIV_W; k++) begin
      if (k < int'(sel)) t = t & div[k];
    end
    return t;
  endfunction

  function automatic logic ext_edge(input logic [1:0] edge_sel, input logic now,
      input logic prev);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = ~now & prev;
    if (edge_sel[1]) return rise | fall;
    else if (edge_sel == EDGE_FALL) return fall;
    else return rise;
  endfunction

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] base,
      input int n);
    return (a >= base) && (a < base + 8'(4 * n)) && (a[1:0] == 2'h0);
  endfunction

  // Free-running prescaler
  always_ff @(posedge SYS_CLK_I) begin
    if (rst) div_r <= '0;
    else div_r <= div_r + 3'h1;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (rst) ext_prev_r <= '0;
    else ext_prev_r <= ext_now;
  end

  // Quadrature on pins A and B for channel 2
  always_comb begin
    ph_up = 1'b0;
    ph_dn = 1'b0;
    if (ext_now[1:0] != ext_prev_r[1:0]) begin
      ph_up = ext_now[0] ^ ext_prev_r[1];
      ph_dn = ~ph_up;
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      logic [2:0] psc;
      psc = ctl_r[c][PSC_HI:PSC_LO];
      unique case (ctl_r[c][CLR_HI:CLR_LO])
        CLR_GRA: own_clr[c] = A_IS_CAPTURE_I[c] ? CAP_A_I[c] : CMP_A_I[c];
        CLR_GRB: own_clr[c] = B_IS_CAPTURE_I[c] ? CAP_B_I[c] : CMP_B_I[c];
        default: own_clr[c] = 1'b0;
      endcase
      if (c == PH_CH && phase_count_enable_r) tick[c] = ph_up | ph_dn;
      else if (psc[2])
        tick[c] = ext_edge(ctl_r[c][EDGE_HI:EDGE_LO], ext_now[psc[1:0]],
                           ext_prev_r[psc[1:0]]);
      else tick[c] = int_tick(psc[1:0], div_r);
    end
  end

  assign sync_hit = |(own_clr & sync_sel_r);

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      clr[c] = own_clr[c] | (ctl_r[c][CLR_HI:CLR_LO] == CLR_SYNC && sync_sel_r[c]
               && sync_hit);
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (rst) begin
      for (int c = 0; c < NUM_CH; c++) cnt_r[c] <= CNT_RST;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (clr[c]) cnt_r[c] <= CNT_RST;
        else if (c == PH_CH && phase_count_enable_r && ph_dn) cnt_r[c] <= cnt_r[c] - 16'h1;
        else if (tick[c]) cnt_r[c] <= cnt_r[c] + 16'h1;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (rst) CNT_CLR_O <= '0;
    else CNT_CLR_O <= clr;
  end

  // Control registers
  always_ff @(posedge SYS_CLK_I) begin
    if (rst) begin
      for (int c = 0; c < NUM_CH; c++) ctl_r[c] <= CTL_RST;
    end else if (wr && PSTRB_I[0] && is_reg(PADDR_I, CTL_BASE, NUM_CH)) begin
      ctl_r[PADDR_I[4:2]] <= PWDATA_I[7:0];
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (rst) begin
      sync_sel_r <= SYNC_RST;
      phase_count_enable_r <= 1'b0;
    end else if (wr && PSTRB_I[0]) begin
      if (PADDR_I == SYNC_OFF) sync_sel_r <= PWDATA_I[4:0];
      if (PADDR_I == PHASE_OFF) phase_count_enable_r <= PWDATA_I[0];
    end
  end

  assign buf_hit = is_reg(PADDR_I, BUF_BASE, NUM_BUF);

  tcc_buf_mem u_buf (
    .clk_i(SYS_CLK_I),
    .rst_i(rst),
    .we_i(wr && buf_hit),
    .be_i(PSTRB_I[1:0]),
    .waddr_i(PADDR_I[3:2]),
    .wdata_i(PWDATA_I[15:0]),
    .raddr_i(PADDR_I[3:2]),
    .rdata_o(buf_rdata)
  );

  always_comb begin
    rd_mux = '0;
    rd_err = 1'b0;
    if (is_reg(PADDR_I, CTL_BASE, NUM_CH)) rd_mux = {24'h0, ctl_r[PADDR_I[4:2]]};
    else if (is_reg(PADDR_I, CNT_BASE, NUM_CH)) rd_mux = {16'h0, cnt_r[PADDR_I[4:2]]};
    else if (buf_hit) rd_mux = {16'h0, buf_rdata};
    else if (PADDR_I == SYNC_OFF) rd_mux = {27'h0, sync_sel_r};
    else if (PADDR_I == PHASE_OFF) rd_mux = {31'h0, phase_count_enable_r};
    else rd_err = 1'b1;
  end

  // One wait state, so read data and the buffer read are both registered
  always_ff @(posedge SYS_CLK_I) begin
    if (rst) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= '0;
    end else begin
      PREADY_O <= acc & ~PREADY_O;
      PSLVERR_O <= acc & ~PREADY_O & rd_err;
      if (acc && !PREADY_O) PRDATA_O <= PWRITE_I ? 32'h0 : rd_mux;
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (rst);

  sequence gra_clear_s;
    ctl_r[3][CLR_HI:CLR_LO] == CLR_GRA && !A_IS_CAPTURE_I[3] && CMP_A_I[3];
  endsequence
  sequence sync_source_s;
    sync_sel_r[0] && sync_sel_r[3] && own_clr[3] && ctl_r[0][CLR_HI:CLR_LO] == CLR_SYNC;
  endsequence
  // Channel 1 on an external pin, one qualifying edge seen this cycle
  sequence ext_rise_s;
    ctl_r[1][PSC_HI] && ctl_r[1][EDGE_HI:EDGE_LO] == EDGE_RISE && !clr[1]
      && ext_now[ctl_r[1][1:0]] && !ext_prev_r[ctl_r[1][1:0]];
  endsequence
  sequence ext_fall_s;
    ctl_r[1][PSC_HI] && ctl_r[1][EDGE_HI:EDGE_LO] == EDGE_FALL && !clr[1]
      && !ext_now[ctl_r[1][1:0]] && ext_prev_r[ctl_r[1][1:0]];
  endsequence
  // Phase mode with both quadrature pins quiet
  sequence phase_idle_s;
    phase_count_enable_r && ext_now[1:0] == ext_prev_r[1:0] && !clr[PH_CH];
  endsequence

  ctl_reset_a: assert property ($past(SRST_I) |-> ctl_r[0] == CTL_RST && ctl_r[4] == CTL_RST)
    else $error("control register not zero after reset");
  rsvd_write_a: assert property (wr && PSTRB_I[0] && PADDR_I == CTL_BASE
      |=> ctl_r[0][RSVD_BIT] == $past(PWDATA_I[RSVD_BIT]))
    else $error("reserved bit write lost");
  gra_clear_a: assert property (gra_clear_s |=> cnt_r[3] == CNT_RST && CNT_CLR_O[3])
    else $error("GENERAL_REG_A compare did not clear counter");
  cap_clear_a: assert property (ctl_r[3][CLR_HI:CLR_LO] == CLR_GRB && B_IS_CAPTURE_I[3]
      && !CAP_B_I[3] && CMP_B_I[3] |-> !clr[3])
    else $error("compare cleared a capture-mode channel");
  sync_clear_a: assert property (sync_source_s |=> cnt_r[0] == CNT_RST && CNT_CLR_O[0])
    else $error("synchronized channel not cleared");
  ext_edge_a: assert property (ctl_r[1][EDGE_HI:EDGE_LO] == EDGE_FALL && ctl_r[1][PSC_HI]
      && ext_now[ctl_r[1][1:0]] && !clr[1] |-> !tick[1])
    else $error("falling-edge channel counted a high level");
  phase_mode_a: assert property (phase_count_enable_r && ext_now[0] != ext_prev_r[0]
      && ext_now[1] == ext_prev_r[1] && !clr[PH_CH] |=> cnt_r[PH_CH] != $past(cnt_r[PH_CH]))
    else $error("phase mode missed a transition");
  int_eighth_a: assert property (ctl_r[0][PSC_HI:PSC_LO] == 3'h3 && !clr[0] && div_r != 3'h7
      && !$past(rst) |=> cnt_r[0] == $past(cnt_r[0]))
    else $error("eighth tap counted off its edge");
  int_full_a: assert property (ctl_r[2][PSC_HI:PSC_LO] == 3'h0 && !phase_count_enable_r
      && !clr[2] |=> cnt_r[2] == $past(cnt_r[2]) + 16'h1)
    else $error("full-rate internal clock did not count");
  pin_sel_a: assert property (ctl_r[1][PSC_HI:PSC_LO] == 3'h7 && ctl_r[1][EDGE_HI]
      && ext_now[3] != ext_prev_r[3] && !clr[1] |=> cnt_r[1] == $past(cnt_r[1]) + 16'h1)
    else $error("pin D both-edge count missed");
  apb_wait_a: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
    else $error("register access not answered in one wait state");

  ext_rise_a: assert property (ext_rise_s |=> cnt_r[1] == $past(cnt_r[1]) + 16'h1)
    else $error("rising pin edge not counted");
  ext_fall_a: assert property (ext_fall_s |=> cnt_r[1] == $past(cnt_r[1]) + 16'h1)
    else $error("falling pin edge not counted");
  phase_idle_a: assert property (phase_idle_s |=> cnt_r[PH_CH] == $past(cnt_r[PH_CH]))
    else $error("phase mode counted without a pin change");
  int_half_a: assert property (ctl_r[0][PSC_HI:PSC_LO] == 3'h1 && !div_r[0] && !clr[0]
      |=> cnt_r[0] == $past(cnt_r[0]))
    else $error("half tap counted off its edge");
  int_quarter_a: assert property (ctl_r[0][PSC_HI:PSC_LO] == 3'h2 && div_r[1:0] == 2'h3
      && !clr[0] |=> cnt_r[0] == $past(cnt_r[0]) + 16'h1)
    else $error("quarter tap missed its edge");
  clr_none_a: assert property (ctl_r[3][CLR_HI:CLR_LO] == CLR_NONE |-> !clr[3])
    else $error("counter cleared with no clear source");
  clr_wins_a: assert property (clr[0] |=> cnt_r[0] == CNT_RST && CNT_CLR_O[0])
    else $error("count won over clear");
  stby_reset_a: assert property ($past(STBY_I) |-> ctl_r[1] == CTL_RST && cnt_r[1] == CNT_RST)
    else $error("standby did not reinitialize channel");
  ctl_last_a: assert property (wr && PSTRB_I[0] && PADDR_I == CTL_BASE + 8'h10
      |=> ctl_r[4] == $past(PWDATA_I[7:0]))
    else $error("last channel control write lost");
  err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error flagged outside a completing access");
endmodule // timer_clock_clear_select
`default_nettype wire
